// ==== design/ccr_defs.vh ====
// constants for the cc logic configuration and status register bank
`ifndef CCR_DEFS_VH
`define CCR_DEFS_VH

// register offsets
`define CCR_OFS_IDENT 8'h01
`define CCR_OFS_CTRL 8'h02
`define CCR_OFS_EVT 8'h03

// control register fields
`define CCR_CTRL_RP_HI 4
`define CCR_CTRL_RP_LO 3
`define CCR_CTRL_ROLE_HI 2
`define CCR_CTRL_ROLE_LO 1
`define CCR_CTRL_MASK 0

// event register fields
`define CCR_EVT_DETACH 1
`define CCR_EVT_ATTACH 0

// field codes and reset values
`define CCR_RP_DEFAULT 2'h0
`define CCR_RP_MEDIUM 2'h1
`define CCR_RP_HIGH 2'h2
`define CCR_RP_RESERVED 2'h3
`define CCR_ROLE_UFP 2'h0
`define CCR_ROLE_DFP 2'h1
`define CCR_ROLE_DRP 2'h2
`define CCR_ROLE_RESERVED 2'h3
`define CCR_MASK_RESET 1'h0

// strap latch delay after reset release, in clock cycles
`define CCR_LATCH_CYCLES 8'h10

`endif

// ==== design/ccr_evt_flag.v ====
// sticky event flag, set by hardware and cleared by a register read
`timescale 1ns/1ps
`default_nettype none

module ccr_evt_flag (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // set and clear
  input wire set,
  input wire clr,
  // state
  output reg flag
);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag <= 1'b0;
    end else if (set) begin
      // set beats a clear in the same cycle so no event is lost
      flag <= 1'b1;
    end else if (clr) begin
      flag <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ==== design/ccr_regs.v ====
// cc logic configuration and status register bank with its two-wire slave
`timescale 1ns/1ps
`default_nettype none
`include "ccr_defs.vh"

// Notes on behaviour
// RQ1: strap pins sampled before bus access allowed
// RQ2: control bits 4:3 choose rp advertisement current
// RQ3: control bits 2:1 choose ufp, dfp, drp
// RQ4: role strap latched as initial role field
// RQ5: host write to role replaces strap role
// RQ6: mask bit suppresses attach/detach interrupt
// RQ7: mask resets zero, interrupts then signalled
// RQ8: host may rewrite strap-derived settings
// RQ9: attach, detach, rp change pull interrupt low
// RQ10: rp field resets to default current
// RQ11: detach bit1, attach bit0, cleared on read

module ccr_regs #(
  parameter [6:0] DEV_ADDR = 7'h1D,
  // identity values are arbitrary
  parameter [4:0] VERSION_CODE = 5'h02,
  parameter [2:0] VENDOR_CODE = 3'h5
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // two-wire bus pins
  input wire scl,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  // strap and detection events
  input wire [1:0] port_role_strap,
  input wire attach_event,
  input wire detach_event,
  input wire rp_change_event,
  // configuration outputs
  output reg [1:0] rp_select,
  output reg [1:0] role_select,
  output reg config_ready,
  output reg interrupt_out_n
);

  // ==========================================================
  // state codes
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_ADDR = 3'h1;
  localparam [2:0] S_ACK_ADDR = 3'h2;
  localparam [2:0] S_WRITE = 3'h3;
  localparam [2:0] S_ACK_WRITE = 3'h4;
  localparam [2:0] S_READ = 3'h5;
  localparam [2:0] S_ACK_READ = 3'h6;

  reg [2:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shift;
  reg [7:0] tx;
  reg [7:0] ptr;
  reg rw;
  reg first_byte;
  reg nack;
  reg scl_q;
  reg sda_q;
  reg int_mask;
  reg rp_flag;
  reg [7:0] latch_cnt;
  wire [1:0] evt_flags;
  wire [1:0] evt_set;

  // ==========================================================
  // bus edge and condition detection
  wire scl_rise = scl & ~scl_q;
  wire scl_fall = ~scl & scl_q;
  wire start_cond = scl & scl_q & sda_q & ~sda_in;
  wire stop_cond = scl & scl_q & ~sda_q & sda_in;
  // clear on the same edge that loads the byte, so a new event in that cycle wins
  wire rd_clear = scl_fall & (ptr == `CCR_OFS_EVT) &
    (((state == S_ACK_ADDR) & rw) | ((state == S_ACK_READ) & ~nack)); // [RQ11]

  function [7:0] read_mux;
    input [7:0] ofs;
    begin
      case (ofs)
        `CCR_OFS_IDENT: read_mux = {VERSION_CODE, VENDOR_CODE};
        `CCR_OFS_CTRL: read_mux = {3'h0, rp_select, role_select, int_mask};
        `CCR_OFS_EVT: read_mux = {6'h00, evt_flags};
        default: read_mux = 8'h00;
      endcase
    end
  endfunction

  wire [7:0] rd_byte = read_mux(ptr);

  // ==========================================================
  // event flags
  assign evt_set[`CCR_EVT_ATTACH] = attach_event;
  assign evt_set[`CCR_EVT_DETACH] = detach_event;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_flag
      ccr_evt_flag u_flag (
        .clk(clk),
        .rst_n(rst_n),
        .set(evt_set[gi]),
        .clr(rd_clear),
        .flag(evt_flags[gi])
      ); // [RQ11]
    end
  endgenerate

  // rp change has no status bit; it is held until the event register is read
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rp_flag <= 1'b0;
    end else if (rp_change_event) begin
      rp_flag <= 1'b1;
    end else if (rd_clear) begin
      rp_flag <= 1'b0;
    end
  end

  // mask gates only attach and detach, never the rp change
  wire next_irq = (|(evt_flags & {2{~int_mask}})) | rp_flag; // [RQ6] [RQ7] [RQ9]

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_out_n <= 1'b1;
    end else begin
      interrupt_out_n <= ~next_irq; // [RQ9]
    end
  end

  // ==========================================================
  // strap latch after reset release
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_cnt <= 8'h00;
      config_ready <= 1'b0;
    end else if (!config_ready) begin
      if (latch_cnt == `CCR_LATCH_CYCLES) begin
        config_ready <= 1'b1; // [RQ1]
      end else begin
        latch_cnt <= latch_cnt + 8'h01;
      end
    end
  end

  // ==========================================================
  // two-wire slave and register writes
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      tx <= 8'h00;
      ptr <= 8'h00;
      rw <= 1'b0;
      first_byte <= 1'b0;
      nack <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      rp_select <= `CCR_RP_DEFAULT; // [RQ10]
      role_select <= `CCR_ROLE_UFP;
      int_mask <= `CCR_MASK_RESET; // [RQ7]
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
      sda_out <= 1'b0;
      if (!config_ready && latch_cnt == `CCR_LATCH_CYCLES) begin
        // strap code 11 has no role, so it falls back to dual role
        if (port_role_strap == `CCR_ROLE_RESERVED) begin
          role_select <= `CCR_ROLE_DRP; // [RQ4]
        end else begin
          role_select <= port_role_strap; // [RQ4] [RQ1]
        end
      end
      if (start_cond && config_ready) begin
        state <= S_ADDR;
        bit_cnt <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop_cond) begin
        state <= S_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          S_IDLE: begin
            sda_oe <= 1'b0;
          end
          S_ADDR, S_WRITE: begin
            if (scl_rise) begin
              shift <= {shift[6:0], sda_in};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              if (state == S_ADDR) begin
                // no answer to a foreign address, the slave stays silent
                if (shift[7:1] == DEV_ADDR) begin
                  sda_oe <= 1'b1;
                  rw <= shift[0];
                  state <= S_ACK_ADDR;
                end else begin
                  state <= S_IDLE;
                end
              end else begin
                sda_oe <= 1'b1;
                state <= S_ACK_WRITE;
                first_byte <= 1'b0;
                if (first_byte) begin
                  ptr <= shift;
                end else begin
                  ptr <= ptr + 8'h01;
                  if (ptr == `CCR_OFS_CTRL) begin
                    // reserved codes 11 leave the field as it was
                    if (shift[`CCR_CTRL_RP_HI:`CCR_CTRL_RP_LO] != `CCR_RP_RESERVED) begin
                      rp_select <= shift[`CCR_CTRL_RP_HI:`CCR_CTRL_RP_LO]; // [RQ2] [RQ8]
                    end
                    if (shift[`CCR_CTRL_ROLE_HI:`CCR_CTRL_ROLE_LO] != `CCR_ROLE_RESERVED) begin
                      role_select <= shift[`CCR_CTRL_ROLE_HI:`CCR_CTRL_ROLE_LO]; // [RQ3] [RQ5] [RQ8]
                    end
                    int_mask <= shift[`CCR_CTRL_MASK]; // [RQ6]
                  end
                end
              end
            end
          end
          S_ACK_ADDR: begin
            if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (rw) begin
                tx <= rd_byte;
                sda_oe <= ~rd_byte[7];
                ptr <= ptr + 8'h01;
                state <= S_READ;
              end else begin
                sda_oe <= 1'b0;
                first_byte <= 1'b1;
                state <= S_WRITE;
              end
            end
          end
          S_ACK_WRITE: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              bit_cnt <= 4'h0;
              state <= S_WRITE;
            end
          end
          S_READ: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt == 4'h8) begin
                sda_oe <= 1'b0;
                state <= S_ACK_READ;
              end else begin
                tx <= {tx[6:0], 1'b0};
                sda_oe <= ~tx[6];
              end
            end
          end
          S_ACK_READ: begin
            if (scl_rise) begin
              nack <= sda_in;
            end else if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (nack) begin
                state <= S_IDLE;
              end else begin
                tx <= rd_byte;
                sda_oe <= ~rd_byte[7];
                ptr <= ptr + 8'h01;
                state <= S_READ;
              end
            end
          end
          default: begin
            state <= S_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ==== dv/cc_logic_config_status_regs_test.sv ====
// self-checking bench for the cc register bank
`timescale 1ns/1ps
`default_nettype none
// ==========
// bench top
module cc_logic_config_status_regs_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] port_role_strap = 2'h2;
  logic attach_event = 1'b0;
  logic detach_event = 1'b0;
  logic rp_change_event = 1'b0;
  wire scl, sda_in, sda_out, sda_oe, config_ready, interrupt_out_n;
  wire [1:0] rp_select, role_select;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  logic [7:0] q;
  logic k;
  always #10 clk = ~clk;
  ccr_regs dut (.*);
  ccr_i2c_host h (.*);
  task complete_run;
    if (fails == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    h.start;
    h.xfer(8'h3A, 1'b1, q, k);
    chk({7'h00, k}, 8'h00);
    h.xfer(a, 1'b1, q, k);
    h.xfer(d, 1'b1, q, k);
    h.stop;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    h.start;
    h.xfer(8'h3A, 1'b1, q, k);
    h.xfer(a, 1'b1, q, k);
    h.start;
    h.xfer(8'h3B, 1'b1, q, k);
    h.xfer(8'hFF, 1'b1, q, k);
    h.stop;
    chk(q, e);
  endtask
  task ev(input logic [2:0] e, input logic [7:0] pin);
    @(negedge clk) {rp_change_event, detach_event, attach_event} = e;
    @(negedge clk) {rp_change_event, detach_event, attach_event} = 3'h0;
    repeat (3) @(negedge clk);
    chk({7'h00, interrupt_out_n}, pin);
  endtask
  // hang guard, run needs about 7k cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      complete_run;
    end
  end
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    chk({2'h0, rp_select, role_select, config_ready, interrupt_out_n}, 8'h01);
    // a start before ready must go unanswered
    h.start;
    h.xfer(8'h3A, 1'b1, q, k);
    chk({7'h00, k}, 8'h01);
    h.stop;
    chk({4'h0, rp_select, role_select}, 8'h02);
    rd(8'h01, {5'h02, 3'h5});
    rd(8'h02, 8'h04);
    for (int i = 0; i < 3; i++) begin
      wr(8'h02, {3'h0, i[1:0], 2'(2 - i), 1'b0});
      chk({4'h0, rp_select, role_select}, {4'h0, i[1:0], 2'(2 - i)});
      rd(8'h02, {3'h0, i[1:0], 2'(2 - i), 1'b0});
    end
    wr(8'h02, 8'h1F);
    rd(8'h02, 8'h11);
    ev(3'h1, 8'h01);
    rd(8'h03, 8'h01);
    rd(8'h03, 8'h00);
    wr(8'h02, 8'h10);
    ev(3'h2, 8'h00);
    rd(8'h03, 8'h02);
    ev(3'h4, 8'h00);
    rd(8'h03, 8'h00);
    chk({7'h00, interrupt_out_n}, 8'h01);
    rd(8'h07, 8'h00);
    wr(8'h02, 8'h01);
    rd(8'h02, 8'h01);
    // mid-run resets with strap codes 1 and 3
    for (int s = 1; s < 4; s += 2) begin
      @(negedge clk) rst_n = 1'b0;
      port_role_strap = 2'(s);
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      chk({2'h0, rp_select, role_select, config_ready, interrupt_out_n}, 8'h01);
      repeat (20) @(negedge clk);
      rd(8'h02, {5'h00, 2'(s == 3 ? 2 : s), 1'b0});
    end
    complete_run;
  end
endmodule
`default_nettype wire

// ==== dv/ccr_i2c_host.sv ====
// two-wire bus master model
`timescale 1ns/1ps
`default_nettype none
// ==========
// host model
module ccr_i2c_host (
  // clock
  input wire logic clk,
  // slave drive
  input wire logic sda_oe,
  input wire logic sda_out,
  // wires
  output logic scl,
  output wire logic sda_in
);
  logic sda_m = 1'b1;
  initial scl = 1'b1;
  // pull-up, released wire reads high
  assign sda_in = sda_m & ~(sda_oe & ~sda_out);
  // 4 clk phases, margin over the 1 clk minimum
  task hp;
    repeat (4) @(negedge clk);
  endtask
  task bitx(input logic b, output logic r);
    @(negedge clk) sda_m = b;
    hp;
    scl = 1'b1;
    hp;
    r = sda_in;
    scl = 1'b0;
  endtask
  task start;
    sda_m = 1'b1;
    hp;
    scl = 1'b1;
    hp;
    sda_m = 1'b0;
    hp;
    scl = 1'b0;
  endtask
  task stop;
    @(negedge clk) sda_m = 1'b0;
    hp;
    scl = 1'b1;
    hp;
    sda_m = 1'b1;
    hp;
  endtask
  task xfer(input logic [7:0] d, input logic mack, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(mack, ack);
  endtask
endmodule
`default_nettype wire

// ==== dv/ccr_regs_checker.sv ====
// checker for the cc register bank
`timescale 1ns/1ps
`default_nettype none
// ==========
// assertions
module ccr_regs_checker (
  // clock
  input wire logic clk,
  input wire logic rst_n,
  // bus
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // events
  input wire logic [1:0] port_role_strap,
  input wire logic attach_event,
  input wire logic detach_event,
  input wire logic rp_change_event,
  // config
  input wire logic [1:0] rp_select,
  input wire logic [1:0] role_select,
  input wire logic config_ready,
  input wire logic interrupt_out_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_ready_delay: assert property ($rose(rst_n) |-> ##16 !config_ready ##1 config_ready)
    else $error("ready timing");
  a_no_early_ack: assert property (!config_ready |-> !sda_oe)
    else $error("ack before ready");
  a_strap_role: assert property ($rose(config_ready) |-> role_select == (&port_role_strap ? 2'h2 : port_role_strap))
    else $error("strap role");
  a_reset_config: assert property (!config_ready |-> rp_select == 2'h0 && role_select == 2'h0)
    else $error("reset config");
  a_rp_legal: assert property (rp_select != 2'h3)
    else $error("rp code");
  a_role_legal: assert property (role_select != 2'h3)
    else $error("role code");
  a_rp_int: assert property (rp_change_event |-> ##2 !interrupt_out_n)
    else $error("rp interrupt");
  a_write_on_ack: assert property ($changed(rp_select) |-> ##[0:1] sda_oe)
    else $error("config change");
endmodule
bind ccr_regs ccr_regs_checker chk (.*);
`default_nettype wire
